// *** hw/lmsf_pkg.sv ***
/*
  Shared constants and carrier types of the link mode switch and flow controller.
  Assumes a 16-bit settings area at word addresses 100H..11FH.
*/
package lmsf_pkg;
  localparam logic [8:0]  AREA_BASE      = 9'h100;
  localparam logic [8:0]  OFS_MODE_WORD  = 9'h119;
  localparam logic [8:0]  OFS_FLOW_SEL   = 9'h11a;
  localparam int          AREA_WORDS     = 32;
  localparam logic [15:0] AREA_DEFAULT   = 16'h0000;
  localparam logic [15:0] FLOW_DEFAULT   = 16'h0001;
  localparam logic [15:0] FLOW_OFF       = 16'h0001;
  localparam logic [15:0] FLOW_DC_A      = 16'h0101;
  localparam logic [15:0] FLOW_DC_B      = 16'h0201;
  localparam logic [15:0] FLOW_DC_C      = 16'h0301;
  localparam logic [7:0]  SW_REQ_CODE    = 8'h01;
  localparam logic [7:0]  SW_DONE_CODE   = 8'h02;
  localparam logic [3:0]  MODE_NOPROT    = 4'h4;
  localparam logic [3:0]  MODE_DED_LO    = 4'h5;
  localparam logic [3:0]  MODE_DED_HI    = 4'h8;
  localparam logic [7:0]  CODE_DC1       = 8'h11;
  localparam logic [7:0]  CODE_DC3       = 8'h13;
  localparam int          SWITCH_NS      = 16;
  localparam int          CLK_NS         = 4;
  localparam int          SWITCH_CYCLES  = (SWITCH_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } lmsf_bus_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } lmsf_byte_type;
endpackage

// *** hw/lmsf_ctrl.sv ***
/*
  Mode switch sequencing and DC1/DC3 flow control of a serial link controller.
  Assumes the protocol engine, host bus and serial framer share sys_clk_in;
  the host switch request and the duplex strap arrive from outside and are synchronised.
*/
// What this block does
// - After remote write response, drop ready, switch mode, default settings except word.
// - Remote switch end raises ready and sets word upper byte to 02H.
// - Remote path only allows dedicated mode to no-protocol mode.
// - Switching proceeds even while the host controller is stopped.
// - Host request: drop ready, switch, default settings, then raise ready and done.
// - Flow select 0101H/0201H/0301H enables DC control, 0001H disables it.
// - DC1/DC3 control only on a full duplex link.
// - Received DC codes act; transmit data passes unaltered.
// - In no-protocol mode device signals its receive ability with DC1/DC3.
// - Clear request empties receive buffer and staging area.
// - Staging full: each byte sets serial error flag and is dropped.
// - After reset or mode change act as if DC1 already sent.
// - Received DC3 pauses transmission and is removed from user data.
// - Received DC1 resumes from pause point and is not delivered.
// - Further DC1 after the first is ignored and dropped.
`timescale 1ns/1ns
module lmsf_ctrl #(
  parameter int         STAGE_DEPTH = 16,
  parameter int         LOW_FREE    = 4,
  parameter int         HIGH_FREE   = 8,
  parameter logic [3:0] INIT_MODE   = 4'h5
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire lmsf_pkg::lmsf_bus_type host_bus_in,
  output logic [15:0]                host_rdata_out,
  input  wire logic                  remote_wr_in,
  input  wire logic [15:0]           remote_wdata_in,
  input  wire logic                  remote_resp_sent_in,
  input  wire logic                  mode_switch_req_in,
  input  wire logic                  full_duplex_in,
  output logic                       module_ready_out,
  output logic                       mode_switch_done_out,
  output logic [3:0]                 mode_out,
  input  wire lmsf_pkg::lmsf_byte_type rx_in,
  input  wire logic                  clear_rx_in,
  input  wire logic                  err_clear_in,
  output logic                       serial_error_flag_out,
  output lmsf_pkg::lmsf_byte_type    user_rx_out,
  input  wire logic                  user_rx_ready_in,
  input  wire lmsf_pkg::lmsf_byte_type tx_in,
  output logic                       tx_ready_out,
  output lmsf_pkg::lmsf_byte_type    link_tx_out,
  input  wire logic                  link_tx_ready_in
);
  localparam int AW = $clog2(STAGE_DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(STAGE_DEPTH);
  localparam logic [AW:0] LOW_C   = (AW+1)'(LOW_FREE);
  localparam logic [AW:0] HIGH_C  = (AW+1)'(HIGH_FREE);
  localparam logic [2:0]  SW_C    = 3'(lmsf_pkg::SWITCH_CYCLES);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_RESP, ST_SWITCH, ST_HOLD_DONE} lmsf_state_type;

  lmsf_state_type state_ff;
  logic [15:0]    area_ff [lmsf_pkg::AREA_WORDS];
  logic [3:0]     mode_ff;
  logic           remote_ff, ready_ff, done_ff;
  logic [2:0]     sw_cnt_ff;
  logic           req_s1_ff, req_s2_ff, dup_s1_ff, dup_s2_ff;
  logic [7:0]     stage_ff [STAGE_DEPTH];
  logic [AW-1:0]  wr_ptr_ff, rd_ptr_ff;
  logic [AW:0]    count_ff;
  logic           err_ff, paused_ff, dc1_sent_ff;
  logic [7:0]     out_byte_ff;
  logic           out_valid_ff;
  logic [15:0]    flow_sel, mode_word;
  logic           flow_on, in_area, rx_is_dc, push, pop, need_dc3, need_dc1, load_free;
  logic [AW:0]    free_cnt;
  logic [4:0]     area_idx;

  // Synchronise the host request and duplex strap
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      dup_s1_ff <= 1'b0;
      dup_s2_ff <= 1'b0;
    end else begin
      req_s1_ff <= mode_switch_req_in;
      req_s2_ff <= req_s1_ff;
      dup_s1_ff <= full_duplex_in;
      dup_s2_ff <= dup_s1_ff;
    end
  end

  // Decode of the settings area and the flow selection
  assign in_area   = (host_bus_in.addr[8:5] == lmsf_pkg::AREA_BASE[8:5]);
  assign area_idx  = host_bus_in.addr[4:0];
  assign flow_sel  = area_ff[5'(lmsf_pkg::OFS_FLOW_SEL - lmsf_pkg::AREA_BASE)];
  assign mode_word = area_ff[5'(lmsf_pkg::OFS_MODE_WORD - lmsf_pkg::AREA_BASE)];
  assign flow_on = (mode_ff == lmsf_pkg::MODE_NOPROT) && dup_s2_ff &&
                   (flow_sel == lmsf_pkg::FLOW_DC_A || flow_sel == lmsf_pkg::FLOW_DC_B ||
                    flow_sel == lmsf_pkg::FLOW_DC_C);

  // Switch sequencer; no host run state is consulted
  // switch regardless of host
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff  <= ST_IDLE;
      remote_ff <= 1'b0;
      ready_ff  <= 1'b1;
      done_ff   <= 1'b0;
      sw_cnt_ff <= 3'h0;
      mode_ff   <= INIT_MODE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (remote_wr_in && remote_wdata_in[15:8] == lmsf_pkg::SW_REQ_CODE &&
              remote_wdata_in[3:0] == lmsf_pkg::MODE_NOPROT &&
              mode_ff >= lmsf_pkg::MODE_DED_LO && mode_ff <= lmsf_pkg::MODE_DED_HI) begin
            state_ff  <= ST_WAIT_RESP;
            remote_ff <= 1'b1;
          end else if (req_s2_ff) begin
            state_ff  <= ST_SWITCH;
            remote_ff <= 1'b0;
            ready_ff  <= 1'b0;
            sw_cnt_ff <= SW_C;
          end
        end
        ST_WAIT_RESP: begin
          if (remote_resp_sent_in) begin
            state_ff  <= ST_SWITCH;
            ready_ff  <= 1'b0;
            sw_cnt_ff <= SW_C;
          end
        end
        ST_SWITCH: begin
          if (sw_cnt_ff == SW_C)
            mode_ff <= mode_word[3:0];
          if (sw_cnt_ff != 3'h0) begin
            sw_cnt_ff <= sw_cnt_ff - 3'h1;
          end else begin
            ready_ff <= 1'b1;
            done_ff  <= !remote_ff;
            state_ff <= remote_ff ? ST_IDLE : ST_HOLD_DONE;
          end
        end
        ST_HOLD_DONE: begin
          if (!req_s2_ff) begin
            done_ff  <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Settings area; switch restores defaults and hardware beats host writes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < lmsf_pkg::AREA_WORDS; i++)
        area_ff[i] <= lmsf_pkg::AREA_DEFAULT;
      area_ff[5'(lmsf_pkg::OFS_FLOW_SEL - lmsf_pkg::AREA_BASE)] <= lmsf_pkg::FLOW_DEFAULT;
    end else if (state_ff == ST_SWITCH && sw_cnt_ff == SW_C) begin
      for (int i = 0; i < lmsf_pkg::AREA_WORDS; i++)
        if (5'(i) != 5'(lmsf_pkg::OFS_MODE_WORD - lmsf_pkg::AREA_BASE))
          area_ff[i] <= lmsf_pkg::AREA_DEFAULT;
      area_ff[5'(lmsf_pkg::OFS_FLOW_SEL - lmsf_pkg::AREA_BASE)] <= lmsf_pkg::FLOW_DEFAULT;
    end else if (state_ff == ST_SWITCH && sw_cnt_ff == 3'h0 && remote_ff) begin
      area_ff[5'(lmsf_pkg::OFS_MODE_WORD - lmsf_pkg::AREA_BASE)][15:8] <= lmsf_pkg::SW_DONE_CODE;
    end else if (remote_wr_in && state_ff == ST_IDLE) begin
      area_ff[5'(lmsf_pkg::OFS_MODE_WORD - lmsf_pkg::AREA_BASE)] <= remote_wdata_in;
    end else if (host_bus_in.wr && in_area) begin
      area_ff[area_idx] <= host_bus_in.wdata;
    end
  end

  // Registered read; outside the area reads zero
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      host_rdata_out <= 16'h0000;
    else if (host_bus_in.rd)
      host_rdata_out <= in_area ? area_ff[area_idx] : 16'h0000;
  end

  // Receive classification
  assign rx_is_dc = flow_on && (rx_in.data == lmsf_pkg::CODE_DC1 || rx_in.data == lmsf_pkg::CODE_DC3);
  assign push     = rx_in.valid && !rx_is_dc && count_ff != DEPTH_C && !clear_rx_in;
  assign pop      = (count_ff != '0) && user_rx_ready_in && !clear_rx_in;
  assign free_cnt = DEPTH_C - count_ff;

  // Staging area pointers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (clear_rx_in || state_ff == ST_SWITCH) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(STAGE_DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(STAGE_DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Staging storage
  always_ff @(posedge sys_clk_in) begin
    if (push)
      stage_ff[wr_ptr_ff] <= rx_in.data;
  end

  assign user_rx_out.valid = (count_ff != '0);
  assign user_rx_out.data  = stage_ff[rd_ptr_ff];

  // Overflow flag; a new overflow wins over a clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      err_ff <= 1'b0;
    else if (rx_in.valid && !rx_is_dc && count_ff == DEPTH_C)
      err_ff <= 1'b1;
    else if (err_clear_in)
      err_ff <= 1'b0;
  end
  assign serial_error_flag_out = err_ff;

  // Pause state from received DC codes
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      paused_ff <= 1'b0;
    else if (state_ff == ST_SWITCH)
      paused_ff <= 1'b0;
    else if (rx_in.valid && rx_is_dc && rx_in.data == lmsf_pkg::CODE_DC3)
      paused_ff <= 1'b1;
    else if (rx_in.valid && rx_is_dc && rx_in.data == lmsf_pkg::CODE_DC1)
      paused_ff <= 1'b0;
  end

  // Own receive ability, hysteresis between the two marks
  // device signals ability
  assign need_dc3  = flow_on && dc1_sent_ff && free_cnt < LOW_C;
  assign need_dc1  = flow_on && !dc1_sent_ff && free_cnt >= HIGH_C;
  assign load_free = !out_valid_ff || link_tx_ready_in;
  assign tx_ready_out = load_free && !need_dc3 && !need_dc1 && !paused_ff;

  // Transmit holding register; DC codes take the slot ahead of user data
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_valid_ff <= 1'b0;
      out_byte_ff  <= 8'h00;
      dc1_sent_ff  <= 1'b1;
    end else if (state_ff == ST_SWITCH) begin
      out_valid_ff <= 1'b0;
      dc1_sent_ff  <= 1'b1;
    end else if (load_free) begin
      out_valid_ff <= need_dc3 || need_dc1 || (tx_in.valid && tx_ready_out);
      if (need_dc3) begin
        out_byte_ff <= lmsf_pkg::CODE_DC3;
        dc1_sent_ff <= 1'b0;
      end else if (need_dc1) begin
        out_byte_ff <= lmsf_pkg::CODE_DC1;
        dc1_sent_ff <= 1'b1;
      end else if (tx_in.valid && tx_ready_out) begin
        out_byte_ff <= tx_in.data;
      end
    end
  end

  assign link_tx_out.valid    = out_valid_ff;
  assign link_tx_out.data     = out_byte_ff;
  assign module_ready_out     = ready_ff;
  assign mode_switch_done_out = done_ff;
  assign mode_out             = mode_ff;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_sw_start;
    state_ff == ST_SWITCH && sw_cnt_ff == SW_C;
  endsequence
  sequence s_sw_tail;
    !ready_ff [*5] ##1 ready_ff;
  endsequence

  property p_sw_ready;
    s_sw_start |-> s_sw_tail;
  endproperty
  a_sw_ready: assert property (p_sw_ready) else $error("ready not low for the switch");

  property p_remote_mark;
    s_sw_start ##0 remote_ff |-> ##5 mode_word[15:8] == lmsf_pkg::SW_DONE_CODE && ready_ff;
  endproperty
  a_remote_mark: assert property (p_remote_mark) else $error("remote mark missing");

  property p_host_done;
    s_sw_start ##0 !remote_ff |-> ##5 done_ff && ready_ff;
  endproperty
  a_host_done: assert property (p_host_done) else $error("done not raised with ready");

  property p_remote_reject;
    state_ff == ST_IDLE && remote_wr_in && mode_ff == lmsf_pkg::MODE_NOPROT |=> state_ff != ST_WAIT_RESP;
  endproperty
  a_remote_reject: assert property (p_remote_reject) else $error("remote switch accepted");

  property p_clear;
    clear_rx_in |=> count_ff == '0 && !user_rx_out.valid;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left data");

  property p_overflow;
    rx_in.valid && !rx_is_dc && count_ff == DEPTH_C && !clear_rx_in && state_ff != ST_SWITCH
      |=> err_ff && count_ff == DEPTH_C - (AW+1)'($past(pop));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_dc3_pause;
    rx_in.valid && rx_is_dc && rx_in.data == lmsf_pkg::CODE_DC3 && state_ff != ST_SWITCH && !clear_rx_in
      |=> paused_ff && !tx_ready_out && count_ff == $past(count_ff) - (AW+1)'($past(pop));
  endproperty
  a_dc3_pause: assert property (p_dc3_pause) else $error("DC3 not acted on");

  property p_no_dc1_after_sw;
    s_sw_start |=> dc1_sent_ff && !out_valid_ff;
  endproperty
  a_no_dc1_after_sw: assert property (p_no_dc1_after_sw) else $error("DC1 state wrong");

  property p_tx_unaltered;
    tx_in.valid && tx_ready_out && state_ff != ST_SWITCH |=> out_valid_ff && out_byte_ff == $past(tx_in.data);
  endproperty
  a_tx_unaltered: assert property (p_tx_unaltered) else $error("tx byte altered");
endmodule // lmsf_ctrl

// *** test/lmsf_far_end.sv ***
/*
  Far-end computer model on the serial link: sends queued bytes and collects sent ones.
  Assumes bytes cross on rising edges of the shared clock.
*/
`timescale 1ns/1ns
module lmsf_far_end (
  input  wire logic                    clk_in,
  input  wire lmsf_pkg::lmsf_byte_type link_tx_in,
  output lmsf_pkg::lmsf_byte_type      rx_out,
  output logic                         tx_ready_out
);
  logic [7:0] pend[$];
  logic [7:0] got[$];
  logic       slow = 1'b0;

  initial rx_out = '0;
  initial tx_ready_out = 1'b1;

  // full duplex, plain payload
  // Idle line toggles so a stale byte never looks like data
  always @(negedge clk_in) begin
    if (pend.size() > 0 && !rx_out.valid) begin
      rx_out <= '{valid: 1'b1, data: pend.pop_front()};
    end else begin
      rx_out <= '{valid: 1'b0, data: ~rx_out.data};
    end
    tx_ready_out <= slow ? ~tx_ready_out : 1'b1; // Stall every other cycle
  end

  // Collect bytes the device sends
  always @(posedge clk_in) begin
    if (link_tx_in.valid && tx_ready_out) begin
      got.push_back(link_tx_in.data);
    end
  end
endmodule // lmsf_far_end

// *** test/lmsf_ctrl_tb.sv ***
/*
  Self-checking bench of the mode switch and flow controller.
  Assumes the far-end model stands on the serial side; bench plays host and protocol engine.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module lmsf_ctrl_tb;
  logic                    sys_clk = 1'b0;
  logic                    reset_n = 1'b0;
  lmsf_pkg::lmsf_bus_type  host_bus = '0;
  logic [15:0]             rdata;
  logic                    remote_wr = 1'b0;
  logic [15:0]             remote_wdata = 16'h0000;
  logic                    remote_resp = 1'b0;
  logic                    sw_req = 1'b0;
  logic                    duplex = 1'b1;
  logic                    ready;
  logic                    done;
  logic [3:0]              mode;
  lmsf_pkg::lmsf_byte_type rx;
  logic                    clear_rx = 1'b0;
  logic                    err_clear = 1'b0;
  logic                    err;
  lmsf_pkg::lmsf_byte_type user_rx;
  logic                    user_rdy = 1'b0;
  lmsf_pkg::lmsf_byte_type tx_byte = '0;
  logic                    tx_rdy;
  lmsf_pkg::lmsf_byte_type link_tx;
  logic                    link_rdy;
  int                      n_fail = 0;
  int                      compares = 0;

  always #2 sys_clk = ~sys_clk;

  lmsf_ctrl #(.STAGE_DEPTH(16), .LOW_FREE(4), .HIGH_FREE(8), .INIT_MODE(4'h5)) u_lmsf_ctrl (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .host_bus_in(host_bus), .host_rdata_out(rdata),
    .remote_wr_in(remote_wr), .remote_wdata_in(remote_wdata), .remote_resp_sent_in(remote_resp),
    .mode_switch_req_in(sw_req), .full_duplex_in(duplex), .module_ready_out(ready),
    .mode_switch_done_out(done), .mode_out(mode), .rx_in(rx), .clear_rx_in(clear_rx),
    .err_clear_in(err_clear), .serial_error_flag_out(err), .user_rx_out(user_rx),
    .user_rx_ready_in(user_rdy), .tx_in(tx_byte), .tx_ready_out(tx_rdy),
    .link_tx_out(link_tx), .link_tx_ready_in(link_rdy));

  lmsf_far_end u_lmsf_far_end (.clk_in(sys_clk), .link_tx_in(link_tx), .rx_out(rx), .tx_ready_out(link_rdy));

  // Register bus cycles
  task automatic bus_wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    host_bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    host_bus = '0;
  endtask

  task automatic bus_rd(input logic [8:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    host_bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge sys_clk);
    host_bus = '0;
    @(negedge sys_clk);
    `CHK(rdata, e)
  endtask

  // Bounded wait on ready (sel 0) or done (sel 1)
  task automatic wait_sig(input int sel, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge sys_clk);
      if ((sel == 0 ? ready : done) === v) break;
    end
    `CHK(i < lim, 1'b1)
  endtask

  task automatic rx_send(input logic [7:0] b);
    u_lmsf_far_end.pend.push_back(b);
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic pop(input logic [7:0] e);
    @(negedge sys_clk);
    `CHK(user_rx, {1'b1, e})
    user_rdy = 1'b1;
    @(negedge sys_clk);
    user_rdy = 1'b0;
  endtask

  // Hold the byte until the rising edge that takes it
  task automatic tx_send(input logic [7:0] b);
    int i;
    @(negedge sys_clk);
    tx_byte = '{valid: 1'b1, data: b};
    #1;
    for (i = 0; i < 200 && tx_rdy !== 1'b1; i++) begin
      @(negedge sys_clk);
      #1;
    end
    `CHK(i < 200, 1'b1)
    @(negedge sys_clk);
    tx_byte.valid = 1'b0;
  endtask

  task automatic remote_write(input logic [15:0] d);
    @(negedge sys_clk);
    remote_wr = 1'b1;
    remote_wdata = d;
    @(negedge sys_clk);
    remote_wr = 1'b0;
    repeat (3) @(negedge sys_clk);
    remote_resp = 1'b1;
    @(negedge sys_clk);
    remote_resp = 1'b0;
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Tests need about 250 cycles; eighty times that marks a hang
  initial begin
    #80000;
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    int i;
    repeat (12) @(negedge sys_clk);
    `CHK({ready, done, mode, err}, 7'h4a)
    reset_n = 1'b1;
    bus_rd(lmsf_pkg::OFS_FLOW_SEL, lmsf_pkg::FLOW_DEFAULT);
    bus_rd(9'h0f0, 16'h0000);
    bus_wr(lmsf_pkg::AREA_BASE, 16'h1234);
    remote_write(16'h0104);
    wait_sig(0, 1'b0, 4);
    @(negedge sys_clk);
    `CHK(mode, lmsf_pkg::MODE_NOPROT)
    wait_sig(0, 1'b1, 10);
    bus_rd(lmsf_pkg::OFS_MODE_WORD, {lmsf_pkg::SW_DONE_CODE, 8'h04});
    bus_rd(lmsf_pkg::AREA_BASE, lmsf_pkg::AREA_DEFAULT);
    bus_wr(lmsf_pkg::OFS_MODE_WORD, 16'h0004);
    bus_rd(lmsf_pkg::OFS_MODE_WORD, 16'h0004);
    // Remote path may not leave no-protocol mode
    remote_write(16'h0105);
    repeat (8) @(negedge sys_clk);
    `CHK({ready, mode}, {1'b1, lmsf_pkg::MODE_NOPROT})
    bus_wr(lmsf_pkg::OFS_FLOW_SEL, lmsf_pkg::FLOW_DC_A);
    repeat (4) @(negedge sys_clk);
    `CHK(u_lmsf_far_end.got.size(), 0)
    rx_send(8'h41);
    pop(8'h41);
    u_lmsf_far_end.slow = 1'b1;
    rx_send(lmsf_pkg::CODE_DC3);
    `CHK(user_rx.valid, 1'b0)
    fork
      tx_send(8'h55);
      begin
        repeat (10) @(negedge sys_clk);
        `CHK(u_lmsf_far_end.got.size(), 0)
        rx_send(lmsf_pkg::CODE_DC1);
      end
    join
    repeat (6) @(negedge sys_clk);
    `CHK(u_lmsf_far_end.got[$], 8'h55)
    rx_send(lmsf_pkg::CODE_DC1);
    `CHK(user_rx.valid, 1'b0)
    // Fill staging until refused, then drain
    u_lmsf_far_end.got.delete();
    for (i = 0; i < 16; i++) rx_send(8'h20 + i[7:0]);
    `CHK(u_lmsf_far_end.got[$], lmsf_pkg::CODE_DC3)
    `CHK(err, 1'b0)
    rx_send(8'h5a);
    `CHK(err, 1'b1)
    for (i = 0; i < 16; i++) pop(8'h20 + i[7:0]);
    `CHK(user_rx.valid, 1'b0)
    repeat (6) @(negedge sys_clk);
    `CHK(u_lmsf_far_end.got[$], lmsf_pkg::CODE_DC1)
    rx_send(8'h61);
    rx_send(8'h62);
    clear_rx = 1'b1;
    @(negedge sys_clk);
    clear_rx = 1'b0;
    @(negedge sys_clk);
    `CHK(user_rx.valid, 1'b0)
    err_clear = 1'b1;
    @(negedge sys_clk);
    err_clear = 1'b0;
    @(negedge sys_clk);
    `CHK(err, 1'b0)
    // Half duplex link: DC codes are plain data
    duplex = 1'b0;
    repeat (4) @(negedge sys_clk);
    rx_send(lmsf_pkg::CODE_DC3);
    pop(lmsf_pkg::CODE_DC3);
    `CHK(tx_rdy, 1'b1)
    duplex = 1'b1;
    // Host switch back to a dedicated mode
    bus_wr(lmsf_pkg::OFS_MODE_WORD, 16'h0005);
    sw_req = 1'b1;
    wait_sig(0, 1'b0, 6);
    wait_sig(1, 1'b1, 10);
    `CHK({ready, mode}, {1'b1, lmsf_pkg::MODE_DED_LO})
    bus_rd(lmsf_pkg::OFS_FLOW_SEL, lmsf_pkg::FLOW_DEFAULT);
    sw_req = 1'b0;
    wait_sig(1, 1'b0, 6);
    bus_wr(lmsf_pkg::OFS_FLOW_SEL, lmsf_pkg::FLOW_DC_B);
    bus_rd(lmsf_pkg::OFS_FLOW_SEL, lmsf_pkg::FLOW_DC_B);
    tx_send(lmsf_pkg::CODE_DC3);
    repeat (6) @(negedge sys_clk);
    `CHK(u_lmsf_far_end.got[$], lmsf_pkg::CODE_DC3)
    final_report();
  end
endmodule // lmsf_ctrl_tb
